// ==== ssdt_regs.svh ====
// register offsets, field positions, reset values and timing counts of the delay timers
`ifndef SSDT_REGS_SVH
`define SSDT_REGS_SVH

// ****************************************
// register byte addresses
// ****************************************
`define SSDT_ADDR_CFG 12'h000
`define SSDT_ADDR_DELAY 12'h004
`define SSDT_ADDR_STATUS 12'h008

// ****************************************
// field positions
// ****************************************
`define SSDT_CFG_VOLT_LSB 0
`define SSDT_CFG_RAMP_LSB 8
`define SSDT_CFG_SETP_LSB 16
`define SSDT_CFG_SRC_BIT 24
`define SSDT_DLY_START_LSB 0
`define SSDT_DLY_AUX_LSB 8
`define SSDT_DLY_CAP_LSB 16

// ****************************************
// reset values and limits
// ****************************************
`define SSDT_VOLT_RST 7'h14
`define SSDT_RAMP_RST 7'h0a
`define SSDT_VOLT_MAX 7'h64
`define SSDT_RAMP_MAX 7'h78
`define SSDT_DELAY_RST 7'h01

// ****************************************
// timing
// ****************************************
`define SSDT_CLK_PERIOD_NS 8
`define SSDT_SECOND_NS 1000000000
`define SSDT_SEC_CYCLES (`SSDT_SECOND_NS / `SSDT_CLK_PERIOD_NS)

`endif

// ==== ssdt_pkg.sv ====
// types shared by the delay timer block
package ssdt_pkg;
  typedef logic [6:0] ssdt_delay_t;
  typedef enum logic [1:0] {
    SSDT_T_IDLE = 2'b00,
    SSDT_T_PRE = 2'b01,
    SSDT_T_MAIN = 2'b11,
    SSDT_T_DONE = 2'b10
  } ssdt_tstate_t;
endpackage

// ==== ssdt_delay_timer.sv ====
// one restartable delay timer with an optional leading setpoint phase
`timescale 1ns/1ps
module ssdt_delay_timer (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic trig,
  input wire logic arm,
  input wire logic unit_cycles,
  input wire logic cyc_tick,
  input wire logic sec_tick,
  input wire ssdt_pkg::ssdt_delay_t pre_val,
  input wire ssdt_pkg::ssdt_delay_t val,
  // result
  output logic done
);

  ssdt_pkg::ssdt_tstate_t state_q, state_d;
  ssdt_pkg::ssdt_delay_t cnt_q, cnt_d;
  logic unit_tick;

  // main phase counts in the jumpered unit, setpoint phase always in seconds
  assign unit_tick = unit_cycles ? cyc_tick : sec_tick;

  // ****************************************
  // next state
  // ****************************************
  // first unit may be partial: the timebase is shared and free running
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    if (!arm) begin
      state_d = ssdt_pkg::SSDT_T_IDLE;
      cnt_d = 7'h00;
    end else if (trig) begin
      cnt_d = 7'h00;
      if (pre_val != 7'h00) begin
        state_d = ssdt_pkg::SSDT_T_PRE;
      end else if (val != 7'h00) begin
        state_d = ssdt_pkg::SSDT_T_MAIN;
      end else begin
        state_d = ssdt_pkg::SSDT_T_DONE;
      end
    end else begin
      unique case (state_q)
        ssdt_pkg::SSDT_T_IDLE: begin
        end
        ssdt_pkg::SSDT_T_PRE: begin
          if (sec_tick) begin
            if (cnt_q + 7'h01 == pre_val) begin
              cnt_d = 7'h00;
              state_d = (val != 7'h00) ? ssdt_pkg::SSDT_T_MAIN : ssdt_pkg::SSDT_T_DONE;
            end else begin
              cnt_d = cnt_q + 7'h01;
            end
          end
        end
        ssdt_pkg::SSDT_T_MAIN: begin
          if (unit_tick) begin
            if (cnt_q + 7'h01 == val) begin
              state_d = ssdt_pkg::SSDT_T_DONE;
            end else begin
              cnt_d = cnt_q + 7'h01;
            end
          end
        end
        ssdt_pkg::SSDT_T_DONE: begin
        end
      endcase
    end
  end

  // state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ssdt_pkg::SSDT_T_IDLE;
      cnt_q <= 7'h00;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  assign done = (state_q == ssdt_pkg::SSDT_T_DONE);

  // ****************************************
  // checks
  // ****************************************
  property p_zero_delay;
    @(posedge pclk) disable iff (!presetn)
    (arm && trig && pre_val == 7'h00 && val == 7'h00) |=> done;
  endproperty
  a_zero_delay: assert property (p_zero_delay) else $error("zero delay not immediate");

  property p_restart;
    @(posedge pclk) disable iff (!presetn)
    (arm && trig && (val != 7'h00 || pre_val != 7'h00)) |=> !done;
  endproperty
  a_restart: assert property (p_restart) else $error("timer did not restart");

  property p_disarm;
    @(posedge pclk) disable iff (!presetn)
    !arm |=> !done && cnt_q == 7'h00;
  endproperty
  a_disarm: assert property (p_disarm) else $error("timer kept state while disarmed");

  property p_no_early;
    @(posedge pclk) disable iff (!presetn)
    (state_q == ssdt_pkg::SSDT_T_MAIN && !unit_tick && !trig && arm) |=> !done;
  endproperty
  a_no_early: assert property (p_no_early) else $error("timer expired without a tick");

endmodule

// ==== ssdt_top.sv ====
// terminal board delay timers, contactor sequencing, indicators and settings over apb
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "ssdt_regs.svh"

module ssdt_top #(
  parameter int unsigned SEC_CYCLES = `SSDT_SEC_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // signals from controller and field contacts
  input wire logic start_cmd,
  input wire logic run_signal,
  input wire logic at_speed_signal,
  input wire logic bypass_closed,
  input wire logic fault_status_signal,
  input wire logic fuse_chain_closed,
  input wire logic emer_bypass,
  input wire logic line_cycle,
  // jumpers and switches
  input wire logic start_unit_cycles_jumper,
  input wire logic start_unit_seconds_jumper,
  input wire logic aux_unit_cycles_jumper,
  input wire logic aux_unit_seconds_jumper,
  input wire logic cap_unit_cycles_jumper,
  input wire logic cap_unit_seconds_jumper,
  input wire logic dual_adjust_switch,
  input wire logic bypass_protection_jumper,
  input wire logic [6:0] start_delay_switch,
  input wire logic [6:0] aux_delay_switch,
  input wire logic [6:0] cap_delay_switch,
  // to controller
  output logic start_to_cpu,
  output logic dual_adjust_en,
  output logic cpu_enable,
  output logic cpu_protect_en,
  output logic [6:0] start_voltage_pct,
  output logic [6:0] ramp_time_s,
  // contactor coils and relay contacts
  output logic main_contactor,
  output logic bypass_coil,
  output logic isolation_coil,
  output logic aux_contacts,
  output logic cap_contacts,
  output logic emer_indication,
  // indicators
  output logic led_start,
  output logic led_fault,
  output logic led_fuse,
  output logic led_cap_on,
  output logic led_timed_out
);

  localparam int NPIN = 37;

  // ****************************************
  // helpers
  // ****************************************
  // cycles only when the cycles jumper alone is fitted; seconds otherwise
  function automatic logic unit_is_cycles(input logic cyc_j, input logic sec_j);
    unit_is_cycles = cyc_j && !sec_j;
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [NPIN-1:0] pin_raw, sync1_q, sync2_q;

  assign pin_raw = {cap_delay_switch, aux_delay_switch, start_delay_switch,
                    bypass_protection_jumper, dual_adjust_switch,
                    cap_unit_seconds_jumper, cap_unit_cycles_jumper,
                    aux_unit_seconds_jumper, aux_unit_cycles_jumper,
                    start_unit_seconds_jumper, start_unit_cycles_jumper,
                    line_cycle, emer_bypass, fuse_chain_closed, fault_status_signal,
                    bypass_closed, at_speed_signal, run_signal, start_cmd};

  // two flops per pin; only the second stage is used by logic
  for (genvar i = 0; i < NPIN; i++) begin : g_sync
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sync1_q[i] <= 1'b0;
        sync2_q[i] <= 1'b0;
      end else begin
        sync1_q[i] <= pin_raw[i];
        sync2_q[i] <= sync1_q[i];
      end
    end
  end

  logic start_s, run_s, at_speed_s, byp_s, fault_s, fuse_ok_s, emer_s, line_s;
  logic dual_s, prot_j_s;
  logic start_cyc, aux_cyc, cap_cyc;
  ssdt_pkg::ssdt_delay_t start_sw, aux_sw, cap_sw;

  assign start_s = sync2_q[0];
  assign run_s = sync2_q[1];
  assign at_speed_s = sync2_q[2];
  assign byp_s = sync2_q[3];
  assign fault_s = sync2_q[4];
  assign fuse_ok_s = sync2_q[5];
  assign emer_s = sync2_q[6];
  assign line_s = sync2_q[7];
  assign start_cyc = unit_is_cycles(sync2_q[8], sync2_q[9]);
  assign aux_cyc = unit_is_cycles(sync2_q[10], sync2_q[11]);
  assign cap_cyc = unit_is_cycles(sync2_q[12], sync2_q[13]);
  assign dual_s = sync2_q[14];
  assign prot_j_s = sync2_q[15];
  // bit i of a switch is position i+1 with weight 2**i
  assign start_sw = sync2_q[22:16];
  assign aux_sw = sync2_q[29:23];
  assign cap_sw = sync2_q[36:30];

  // ****************************************
  // timebase and edge detection
  // ****************************************
  logic [31:0] sec_cnt_q, sec_cnt_d;
  logic line_q, start_q, byp_q, sec_tick, cyc_tick;

  // free-running seconds prescaler
  always_comb begin
    sec_cnt_d = (sec_cnt_q == SEC_CYCLES - 1) ? 32'h0000_0000 : sec_cnt_q + 32'h0000_0001;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_cnt_q <= 32'h0000_0000;
      line_q <= 1'b0;
      start_q <= 1'b0;
      byp_q <= 1'b0;
    end else begin
      sec_cnt_q <= sec_cnt_d;
      line_q <= line_s;
      start_q <= start_s;
      byp_q <= byp_s;
    end
  end

  assign sec_tick = (sec_cnt_q == SEC_CYCLES - 1);
  assign cyc_tick = line_s && !line_q; // one tick per line cycle

  // ****************************************
  // registers
  // ****************************************
  logic [6:0] volt_q, volt_d, ramp_q, ramp_d, setp_q, setp_d;
  logic src_q, src_d;
  ssdt_pkg::ssdt_delay_t dly_start_q, dly_start_d, dly_aux_q, dly_aux_d;
  ssdt_pkg::ssdt_delay_t dly_cap_q, dly_cap_d;
  logic [31:0] prdata_q, prdata_d, status;
  logic wr_en, setup, mapped;
  logic [6:0] wr_volt, wr_ramp;
  logic start_done, aux_done, cap_done;

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite;
  assign mapped = (paddr == `SSDT_ADDR_CFG) || (paddr == `SSDT_ADDR_DELAY) ||
                  (paddr == `SSDT_ADDR_STATUS);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_q;
  assign wr_volt = pwdata[`SSDT_CFG_VOLT_LSB +: 7];
  assign wr_ramp = pwdata[`SSDT_CFG_RAMP_LSB +: 7];

  assign status = {19'h0_0000, cap_cyc, aux_cyc, start_cyc, dual_s, byp_s, at_speed_s,
                   run_s, !fuse_ok_s, fault_s, emer_s, cap_done, aux_done, start_done};

  // writes clamp start voltage and ramp time to their legal range; read data captured in setup
  always_comb begin
    volt_d = volt_q;
    ramp_d = ramp_q;
    setp_d = setp_q;
    src_d = src_q;
    dly_start_d = dly_start_q;
    dly_aux_d = dly_aux_q;
    dly_cap_d = dly_cap_q;
    prdata_d = prdata_q;
    if (wr_en && paddr == `SSDT_ADDR_CFG) begin
      volt_d = (wr_volt > `SSDT_VOLT_MAX) ? `SSDT_VOLT_MAX : wr_volt;
      ramp_d = (wr_ramp > `SSDT_RAMP_MAX) ? `SSDT_RAMP_MAX : wr_ramp;
      setp_d = pwdata[`SSDT_CFG_SETP_LSB +: 7];
      src_d = pwdata[`SSDT_CFG_SRC_BIT];
    end
    if (wr_en && paddr == `SSDT_ADDR_DELAY) begin
      dly_start_d = pwdata[`SSDT_DLY_START_LSB +: 7];
      dly_aux_d = pwdata[`SSDT_DLY_AUX_LSB +: 7];
      dly_cap_d = pwdata[`SSDT_DLY_CAP_LSB +: 7];
    end
    if (setup && !pwrite) begin
      unique case (paddr)
        `SSDT_ADDR_CFG: prdata_d = {7'h00, src_q, 1'b0, setp_q, 1'b0, ramp_q, 1'b0, volt_q};
        `SSDT_ADDR_DELAY: prdata_d = {9'h000, dly_cap_q, 1'b0, dly_aux_q, 1'b0, dly_start_q};
        `SSDT_ADDR_STATUS: prdata_d = status;
        default: prdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      volt_q <= `SSDT_VOLT_RST;
      ramp_q <= `SSDT_RAMP_RST;
      setp_q <= 7'h00;
      src_q <= 1'b0;
      dly_start_q <= `SSDT_DELAY_RST;
      dly_aux_q <= `SSDT_DELAY_RST;
      dly_cap_q <= `SSDT_DELAY_RST;
      prdata_q <= 32'h0000_0000;
    end else begin
      volt_q <= volt_d;
      ramp_q <= ramp_d;
      setp_q <= setp_d;
      src_q <= src_d;
      dly_start_q <= dly_start_d;
      dly_aux_q <= dly_aux_d;
      dly_cap_q <= dly_cap_d;
      prdata_q <= prdata_d;
    end
  end

  // ****************************************
  // delay timers
  // ****************************************
  ssdt_pkg::ssdt_delay_t start_val, aux_val, cap_val;

  // switches rule unless software has taken the delays over
  assign start_val = src_q ? dly_start_q : start_sw;
  assign aux_val = src_q ? dly_aux_q : aux_sw;
  assign cap_val = src_q ? dly_cap_q : cap_sw;

  // start delay: armed by the held command outside emergency bypass, restarts on each new press
  ssdt_delay_timer u_start (
    .pclk(pclk), .presetn(presetn),
    .trig(start_s && !start_q), .arm(start_s && !emer_s),
    .unit_cycles(start_cyc), .cyc_tick(cyc_tick), .sec_tick(sec_tick),
    .pre_val(7'h00), .val(start_val), .done(start_done)
  );

  // auxiliary delay from bypass close, after the controller setpoint
  ssdt_delay_timer u_aux (
    .pclk(pclk), .presetn(presetn),
    .trig(byp_s && !byp_q), .arm(byp_s),
    .unit_cycles(aux_cyc), .cyc_tick(cyc_tick), .sec_tick(sec_tick),
    .pre_val(setp_q), .val(aux_val), .done(aux_done)
  );

  // capacitor contactor delay from bypass close, after the setpoint
  ssdt_delay_timer u_cap (
    .pclk(pclk), .presetn(presetn),
    .trig(byp_s && !byp_q), .arm(byp_s),
    .unit_cycles(cap_cyc), .cyc_tick(cyc_tick), .sec_tick(sec_tick),
    .pre_val(setp_q), .val(cap_val), .done(cap_done)
  );

  // ****************************************
  // outputs
  // ****************************************
  logic [14:0] out_q, out_d;

  // emergency bypass removes the controller and runs across the line
  always_comb begin
    out_d[0] = start_done && !emer_s;
    out_d[1] = dual_s;
    out_d[2] = !emer_s;
    out_d[3] = !emer_s || !prot_j_s;
    out_d[4] = run_s;
    out_d[5] = at_speed_s && !emer_s;
    out_d[6] = emer_s ? start_s : run_s;
    out_d[7] = aux_done;
    out_d[8] = cap_done;
    out_d[9] = emer_s;
    out_d[10] = start_s;
    out_d[11] = fault_s;
    out_d[12] = !fuse_ok_s;
    out_d[13] = cap_done;
    out_d[14] = aux_done;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= 15'h0000;
    end else begin
      out_q <= out_d;
    end
  end

  assign start_to_cpu = out_q[0];
  assign dual_adjust_en = out_q[1];
  assign cpu_enable = out_q[2];
  assign cpu_protect_en = out_q[3];
  assign main_contactor = out_q[4];
  assign bypass_coil = out_q[5];
  assign isolation_coil = out_q[6];
  assign aux_contacts = out_q[7];
  assign cap_contacts = out_q[8];
  assign emer_indication = out_q[9];
  assign led_start = out_q[10];
  assign led_fault = out_q[11];
  assign led_fuse = out_q[12];
  assign led_cap_on = out_q[13];
  assign led_timed_out = out_q[14];
  assign start_voltage_pct = volt_q;
  assign ramp_time_s = ramp_q;

  // ****************************************
  // checks
  // ****************************************
  sequence s_run_held;
    run_s [*2];
  endsequence

  property p_main_hold;
    @(posedge pclk) disable iff (!presetn)
    s_run_held |-> main_contactor;
  endproperty
  a_main_hold: assert property (p_main_hold) else $error("main contactor dropped in run");

  property p_bypass;
    @(posedge pclk) disable iff (!presetn)
    (at_speed_s && !emer_s) |=> bypass_coil;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass coil not energized");

  property p_start_gate;
    @(posedge pclk) disable iff (!presetn)
    !start_done |=> !start_to_cpu;
  endproperty
  a_start_gate: assert property (p_start_gate) else $error("start passed before delay");

  sequence s_emer_start;
    emer_s && start_s;
  endsequence

  property p_emer;
    @(posedge pclk) disable iff (!presetn)
    s_emer_start |=> !cpu_enable && isolation_coil && !start_to_cpu;
  endproperty
  a_emer: assert property (p_emer) else $error("emergency bypass sequencing wrong");

  property p_protect;
    @(posedge pclk) disable iff (!presetn)
    (emer_s && prot_j_s) |=> !cpu_protect_en;
  endproperty
  a_protect: assert property (p_protect) else $error("protection left on in bypass");

  property p_limits;
    @(posedge pclk) disable iff (!presetn)
    start_voltage_pct <= `SSDT_VOLT_MAX && ramp_time_s <= `SSDT_RAMP_MAX;
  endproperty
  a_limits: assert property (p_limits) else $error("setting out of range");

  property p_leds;
    @(posedge pclk) disable iff (!presetn)
    ##1 (led_cap_on == $past(cap_done)) && (led_timed_out == $past(aux_done)) &&
    (led_fault == $past(fault_s));
  endproperty
  a_leds: assert property (p_leds) else $error("indicator mismatch");

  property p_unmapped;
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && !mapped) |-> pslverr && pready;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");

endmodule

// ==== ssdt_cpu_model.sv ====
// behavioural model of the controller board relays and the bypass contactor
`timescale 1ns/1ps
module ssdt_cpu_model #(
  parameter int LC_HALF = 4,
  parameter int CLOSE_DLY = 3
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // requests from the bench
  input wire logic run_req,
  input wire logic spd_req,
  input wire logic flt_req,
  // coil driven by the board
  input wire logic bypass_coil,
  // contacts seen by the board
  output logic run_signal,
  output logic at_speed_signal,
  output logic fault_status_signal,
  output logic bypass_closed,
  output logic line_cycle
);
  int lc_cnt;
  int cl_cnt;
  // mains waveform runs free, the line never stops between starts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lc_cnt <= 0;
      line_cycle <= 1'h0;
    end else if (lc_cnt == LC_HALF - 1) begin
      lc_cnt <= 0;
      line_cycle <= ~line_cycle;
    end else begin
      lc_cnt <= lc_cnt + 1;
    end
  end
  // armature lags the coil, so the board never sees an instant close
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cl_cnt <= 0;
      bypass_closed <= 1'h0;
    end else if (bypass_closed == bypass_coil) begin
      cl_cnt <= 0;
    end else if (cl_cnt == CLOSE_DLY - 1) begin
      bypass_closed <= bypass_coil;
    end else begin
      cl_cnt <= cl_cnt + 1;
    end
  end
  // relay contacts follow requests one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_signal <= 1'h0;
      at_speed_signal <= 1'h0;
      fault_status_signal <= 1'h0;
    end else begin
      run_signal <= run_req;
      at_speed_signal <= spd_req;
      fault_status_signal <= flt_req;
    end
  end
endmodule

// ==== tb_top.sv ====
// self-checking bench for the delay timer board
`timescale 1ns/1ps
`include "ssdt_regs.svh"
module tb_top;
  // ****
  // signals
  // ****
  localparam int SEC = 20;
  localparam int LC = 8;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, er;
  logic start_cmd = 1'h0, fuse_chain_closed = 1'h1, emer_bypass = 1'h0;
  logic dual_adjust_switch = 1'h0, bypass_protection_jumper = 1'h1;
  logic run_req = 1'h0, spd_req = 1'h0, flt_req = 1'h0;
  logic start_unit_cycles_jumper = 1'h0, start_unit_seconds_jumper = 1'h1;
  logic aux_unit_cycles_jumper = 1'h0, aux_unit_seconds_jumper = 1'h1;
  logic cap_unit_cycles_jumper = 1'h1, cap_unit_seconds_jumper = 1'h0;
  logic [6:0] start_delay_switch = 7'h01, aux_delay_switch = 7'h01, cap_delay_switch = 7'h02;
  logic run_signal, at_speed_signal, bypass_closed, fault_status_signal, line_cycle;
  logic start_to_cpu, dual_adjust_en, cpu_enable, cpu_protect_en, main_contactor;
  logic bypass_coil, isolation_coil, aux_contacts, cap_contacts, emer_indication;
  logic led_start, led_fault, led_fuse, led_cap_on, led_timed_out;
  logic [6:0] start_voltage_pct, ramp_time_s;
  logic [15:0] obs;
  int err_total = 0, cmp_count = 0, n, na, nc, u;
  // start delay table: switch value and jumper pair {seconds, cycles}
  logic [6:0] dv [0:10] = '{7'h00, 7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40,
                            7'h07, 7'h02, 7'h7f};
  logic [1:0] dj [0:10] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h0, 2'h3};
  ssdt_top #(.SEC_CYCLES(SEC)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .start_cmd, .run_signal, .at_speed_signal, .bypass_closed, .fault_status_signal,
    .fuse_chain_closed, .emer_bypass, .line_cycle, .start_unit_cycles_jumper,
    .start_unit_seconds_jumper, .aux_unit_cycles_jumper, .aux_unit_seconds_jumper,
    .cap_unit_cycles_jumper, .cap_unit_seconds_jumper, .dual_adjust_switch,
    .bypass_protection_jumper, .start_delay_switch, .aux_delay_switch, .cap_delay_switch,
    .start_to_cpu, .dual_adjust_en, .cpu_enable, .cpu_protect_en, .start_voltage_pct,
    .ramp_time_s, .main_contactor, .bypass_coil, .isolation_coil, .aux_contacts,
    .cap_contacts, .emer_indication, .led_start, .led_fault, .led_fuse, .led_cap_on,
    .led_timed_out
  );
  ssdt_cpu_model #(.LC_HALF(LC / 2)) cpu (
    .pclk, .presetn, .run_req, .spd_req, .flt_req, .bypass_coil, .run_signal,
    .at_speed_signal, .fault_status_signal, .bypass_closed, .line_cycle
  );
  // one word of board outputs and the bypass contact, so waits and checks can pick bits
  assign obs = {start_to_cpu, aux_contacts, cap_contacts, bypass_closed, main_contactor,
                bypass_coil, isolation_coil, cpu_enable, cpu_protect_en, led_start, led_fault,
                led_fuse, led_cap_on, led_timed_out, dual_adjust_en, emer_indication};
  always #4 pclk = ~pclk;
  // ****
  // tasks
  // ****
  task automatic complete_run();
    if (err_total == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_lat(input int got, input int lo, input int hi);
    cmp_count++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic chk_bits(input logic [15:0] m, input logic [15:0] e);
    chk({16'h0000, obs & m}, {16'h0000, e});
  endtask
  // a bounded wait, since a stuck timer must not hang the run
  task automatic wait_bit(input int b, input logic v, output int k);
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (obs[b] !== v && k < 4000);
    if (obs[b] !== v) begin
      err_total++;
      complete_run();
    end
  endtask
  // apb transfer; holds the request until pready is sampled high
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 50);
    if (pready !== 1'h1) begin
      err_total++;
      complete_run();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // ****
  // sequence
  // ****
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    apb(`SSDT_ADDR_CFG, 1'h0, 32'h0000_0000);
    chk(rd, 32'h0000_0a14);
    apb(`SSDT_ADDR_DELAY, 1'h0, 32'h0000_0000);
    chk(rd, 32'h0001_0101);
    apb(12'h0f0, 1'h0, 32'h0000_0000);
    chk({31'h0000_0000, er}, 32'h0000_0001);
    apb(`SSDT_ADDR_CFG, 1'h1, 32'h0002_7f7f);
    apb(`SSDT_ADDR_CFG, 1'h0, 32'h0000_0000);
    chk(rd, 32'h0002_7864);
    chk({25'h000_0000, start_voltage_pct}, 32'h0000_0064);
    chk({25'h000_0000, ramp_time_s}, 32'h0000_0078);
    // start delay over every switch weight and every jumper pairing
    for (int i = 0; i < 11; i++) begin
      start_delay_switch <= dv[i];
      {start_unit_seconds_jumper, start_unit_cycles_jumper} <= dj[i];
      u = (dj[i] == 2'h1) ? LC : SEC;
      repeat (4) @(posedge pclk);
      start_cmd <= 1'h1;
      wait_bit(15, 1'h1, n);
      chk_lat(n, (dv[i] == 7'h00) ? 3 : (int'(dv[i]) - 1) * u + 3, int'(dv[i]) * u + 8);
      chk_bits(16'h0040, 16'h0040);
      start_cmd <= 1'h0;
      wait_bit(15, 1'h0, n);
    end
    // run, at speed, then aux and capacitor delays after the setpoint of 2 s
    run_req <= 1'h1;
    wait_bit(11, 1'h1, n);
    chk_lat(n, 2, 8);
    for (int k = 0; k < 2; k++) begin
      spd_req <= 1'h1;
      wait_bit(10, 1'h1, n);
      chk_lat(n, 2, 8);
      wait_bit(12, 1'h1, n);
      fork
        wait_bit(14, 1'h1, na);
        wait_bit(13, 1'h1, nc);
      join
      chk_lat(na, 2 * SEC, 3 * SEC + 8);
      chk_lat(nc, SEC + 3, 2 * SEC + 2 * LC + 8);
      chk_bits(16'h000c, 16'h000c);
      spd_req <= 1'h0;
      wait_bit(12, 1'h0, n);
      repeat (5) @(posedge pclk);
      chk_bits(16'h6c0c, 16'h0800);
    end
    // indicators and the dual adjustment switch
    flt_req <= 1'h1;
    fuse_chain_closed <= 1'h0;
    dual_adjust_switch <= 1'h1;
    repeat (6) @(posedge pclk);
    chk_bits(16'h0032, 16'h0032);
    flt_req <= 1'h0;
    fuse_chain_closed <= 1'h1;
    dual_adjust_switch <= 1'h0;
    repeat (6) @(posedge pclk);
    chk_bits(16'h0032, 16'h0000);
    // emergency bypass, protection jumper fitted then removed
    run_req <= 1'h0;
    spd_req <= 1'h1;
    emer_bypass <= 1'h1;
    repeat (8) @(posedge pclk);
    chk_bits(16'h0781, 16'h0001);
    start_cmd <= 1'h1;
    bypass_protection_jumper <= 1'h0;
    repeat (8) @(posedge pclk);
    chk_bits(16'h8281, 16'h0281);
    // status word in bypass: emergency, at speed, capacitor unit in cycles
    apb(`SSDT_ADDR_STATUS, 1'h0, 32'h0000_0000);
    chk(rd, 32'h0000_1088);
    // software-held delays replace the switches; stray bit 7 must not stick
    emer_bypass <= 1'h0;
    start_cmd <= 1'h0;
    apb(`SSDT_ADDR_DELAY, 1'h1, 32'h007f_0085);
    apb(`SSDT_ADDR_DELAY, 1'h0, 32'h0000_0000);
    chk(rd, 32'h007f_0005);
    apb(`SSDT_ADDR_CFG, 1'h1, 32'h0100_0a14);
    start_cmd <= 1'h1;
    wait_bit(15, 1'h1, n);
    chk_lat(n, 4 * SEC + 3, 5 * SEC + 8);
    complete_run();
  end
endmodule
